// ### logic/sbc_supervisor.sv
/*
  Supervisory core of a system basis chip: mode flow, window watchdog, CAN mode
  gating, forced wake, cyclic sense and local and SPI wake-up.
  Assumes an SPI decoder on MCLK that supplies the write strobes and a flag marking
  a watchdog word; pins and regulator status arrive asynchronously.
*/
`include "sbc_sup_params.svh"
`default_nettype none

// Behaviour
// - CAN in bus standby outside Normal
// - Second regulator off forces standby, no restore
// - Watchdog runs only in Normal and Stand-by
// - Period programmed in Normal Request, changeable later
// - Period is closed window plus open window
// - Open-window trigger clears counter, new closed window
// - Trigger taken on chip select rising edge
// - Early or missing trigger asserts reset output
// - Forced wake to Normal Request, 75 ms timeout
// - Forced wake period from eight cyclic values
// - Cyclic sense overrides forced wake in Sleep
// - Switched-output inputs sensed only while output on
// - Option none ignores wake inputs entirely
// - Level option fires after 20 us filter
// - Change option uses level captured at programming or at the last wake
// - Cyclic sense needs two-plus-two qualified samples for edges, the last two of four for levels
// - Cyclic sense only in Sleep, eight periods
// - Output on 400 us, sample at 300 us
// - Continuous sense in Normal, Stand-by, battery Sleep
// - Live levels readable, flag and masked interrupt
// - Sleep local wake sets flag, resets, Normal Request
// - Chip select fall after regulator off wakes
module sbc_supervisor #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // Asynchronous pins and status
  input wire logic CS_N_PIN,
  input wire logic [2:0] WAKE_PIN,
  input wire logic FIRST_REGULATOR_OFF,
  input wire logic SECOND_REGULATOR_OVERLOAD,
  // SPI decoder strobes and data
  input wire logic TRIG_WORD,
  input wire logic WD_TIMING_WR,
  input wire logic [2:0] WD_TIMING_SEL,
  input wire logic MODE_WR,
  input wire logic [1:0] MODE_CMD,
  input wire logic CAN_MODE_WR,
  input wire logic [1:0] CAN_MODE_REQ,
  input wire logic WAKE_OPT_WR,
  input wire logic [8:0] WAKE_OPT,
  input wire logic [2:0] WAKE_FLAG_CLR,
  input wire logic SPI_WAKE_CLR,
  // Configuration levels
  input wire logic SWITCHED_OUTPUT_EN,
  input wire logic WAKE_INPUTS_ON_SWITCHED_OUTPUT,
  input wire logic [2:0] CYC_SEL,
  input wire logic CYC_SENSE_EN,
  input wire logic FWU_EN,
  input wire logic [2:0] WAKE_INT_EN,
  // Status and control outputs
  output logic [4:0] MODE,
  output logic [1:0] CAN_MODE,
  output logic FIRST_REGULATOR_EN,
  output logic SECOND_REGULATOR_EN,
  output logic SWITCHED_BATTERY_OUTPUT,
  output logic RST_N_OUT,
  output logic [2:0] WAKE_LIVE,
  output logic [2:0] WAKE_FLAG,
  output logic SPI_WAKE_FLAG,
  output logic WAKE_INT
);
  // ========================================================================
  // Declarations
  sbc_sup_pkg::mode_t mode;
  sbc_sup_pkg::mode_t next_mode;
  logic [5:0] pin_s;
  logic cs_s, cs_q, cs_rise, cs_fall, v1_off, v2_ovl;
  logic [2:0] wake_s;
  logic [15:0] pre;
  logic tick, entering, start_rst, wd_active, nreq_to, wd_fault, trig, wd_open;
  logic [7:0] rst_cnt;
  logic [19:0] nreq_cnt, wd_cnt, wd_period, sleep_cnt, cyc_period;
  logic [2:0] wd_sel, cyc_sel_l, lw, sense_cont, flag_set;
  logic cyc_en_l, fwu_en_l, cyc_act, fwu_act, per_end, v3_cyc, sample;
  logic spi_wake, fwu_wake, sleep_wake, v2_on;
  sbc_sup_pkg::can_mode_t can_mode;

  function automatic logic [19:0] ms_ticks(input int unsigned ms);
    return 20'(ms * 1000 / `TICK_US);
  endfunction

  // ========================================================================
  // Input sync; select passes active high so reset matches an idle pin, no false edge
  sync2 #(.W(6)) u_sync (
    .clk(MCLK),
    .rstn(RSTN),
    .d({SECOND_REGULATOR_OVERLOAD, FIRST_REGULATOR_OFF, WAKE_PIN, !CS_N_PIN}),
    .q(pin_s)
  );
  assign cs_s = !pin_s[0];
  assign wake_s = pin_s[3:1];
  assign v1_off = pin_s[4];
  assign v2_ovl = pin_s[5];

  always_ff @(posedge MCLK) begin
    if (!RSTN) cs_q <= 1'b1;
    else cs_q <= cs_s;
  end
  assign cs_rise = cs_s && !cs_q;
  assign cs_fall = !cs_s && cs_q;
  assign trig = cs_rise && TRIG_WORD;

  // ========================================================================
  // Shared timebase, restarted on every mode change
  assign entering = next_mode != mode;

  always_ff @(posedge MCLK) begin
    if (!RSTN || entering || tick) pre <= 16'h0000;
    else pre <= pre + 16'h0001;
  end
  assign tick = pre == 16'(TICK_CYCLES - 1);

  // ========================================================================
  // Mode flow
  always_comb begin
    next_mode = mode;
    start_rst = 1'b0;
    case (mode)
      sbc_sup_pkg::M_NREQ: begin
        // Other commands are ignored until the watchdog timing arrives
        if (MODE_WR && MODE_CMD == sbc_sup_pkg::CMD_EMERG) next_mode = sbc_sup_pkg::M_EMERG;
        else if (WD_TIMING_WR) next_mode = sbc_sup_pkg::M_NORMAL;
        else if (nreq_to) next_mode = sbc_sup_pkg::M_SLEEP;
      end
      sbc_sup_pkg::M_NORMAL, sbc_sup_pkg::M_STANDBY: begin
        if (wd_fault) begin
          next_mode = sbc_sup_pkg::M_NREQ;
          start_rst = 1'b1;
        end else if (MODE_WR) begin
          case (MODE_CMD)
            sbc_sup_pkg::CMD_NORMAL: next_mode = sbc_sup_pkg::M_NORMAL;
            sbc_sup_pkg::CMD_STANDBY: next_mode = sbc_sup_pkg::M_STANDBY;
            sbc_sup_pkg::CMD_SLEEP: next_mode = sbc_sup_pkg::M_SLEEP;
            default: next_mode = sbc_sup_pkg::M_EMERG;
          endcase
        end
      end
      sbc_sup_pkg::M_SLEEP: begin
        if (sleep_wake) begin
          next_mode = sbc_sup_pkg::M_NREQ;
          start_rst = 1'b1;
        end
      end
      sbc_sup_pkg::M_EMERG: next_mode = sbc_sup_pkg::M_EMERG;
      default: next_mode = sbc_sup_pkg::M_NREQ;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) mode <= sbc_sup_pkg::M_NREQ;
    else mode <= next_mode;
  end

  // Reset pulse to the microcontroller, counted in ticks
  always_ff @(posedge MCLK) begin
    if (!RSTN) rst_cnt <= 8'h00;
    else if (start_rst) rst_cnt <= 8'(`RST_PULSE_TICKS);
    else if (tick && rst_cnt != 8'h00) rst_cnt <= rst_cnt - 8'h01;
  end

  // Configuration timeout starts once the reset pulse has ended
  always_ff @(posedge MCLK) begin
    if (!RSTN || entering || mode != sbc_sup_pkg::M_NREQ) nreq_cnt <= 20'h00000;
    else if (tick && rst_cnt == 8'h00 && !nreq_to) nreq_cnt <= nreq_cnt + 20'h00001;
  end
  assign nreq_to = nreq_cnt == 20'(`NREQ_TIMEOUT_TICKS);

  // ========================================================================
  // Window watchdog
  assign wd_active = mode == sbc_sup_pkg::M_NORMAL || mode == sbc_sup_pkg::M_STANDBY;

  always_ff @(posedge MCLK) begin
    if (!RSTN) wd_sel <= `WD_SEL_RST;
    else if (WD_TIMING_WR && mode != sbc_sup_pkg::M_SLEEP && mode != sbc_sup_pkg::M_EMERG)
      wd_sel <= WD_TIMING_SEL;
  end

  always_comb begin
    case (wd_sel)
      3'h0: wd_period = ms_ticks(`WD_MS_0);
      3'h1: wd_period = ms_ticks(`WD_MS_1);
      3'h2: wd_period = ms_ticks(`WD_MS_2);
      3'h3: wd_period = ms_ticks(`WD_MS_3);
      3'h4: wd_period = ms_ticks(`WD_MS_4);
      3'h5: wd_period = ms_ticks(`WD_MS_5);
      3'h6: wd_period = ms_ticks(`WD_MS_6);
      default: wd_period = ms_ticks(`WD_MS_7);
    endcase
  end

  // First half of the period is closed, second half open
  assign wd_open = wd_cnt >= (wd_period >> 1);

  always_ff @(posedge MCLK) begin
    if (!RSTN || !wd_active || entering) wd_cnt <= 20'h00000;
    else if (trig && wd_open) wd_cnt <= 20'h00000;
    else if (tick) wd_cnt <= wd_cnt + 20'h00001;
  end

  assign wd_fault = wd_active && ((trig && !wd_open) || wd_cnt >= wd_period);

  // ========================================================================
  // CAN transceiver mode
  assign v2_on = mode == sbc_sup_pkg::M_NORMAL && !v2_ovl;

  always_ff @(posedge MCLK) begin
    if (!RSTN || !v2_on) can_mode <= sbc_sup_pkg::CAN_BUS_STANDBY;
    else if (CAN_MODE_WR) begin
      case (CAN_MODE_REQ)
        2'h1: can_mode <= sbc_sup_pkg::CAN_RECEIVE_ONLY;
        2'h2: can_mode <= sbc_sup_pkg::CAN_TRANSMIT_RECEIVE;
        default: can_mode <= sbc_sup_pkg::CAN_BUS_STANDBY;
      endcase
    end
  end

  // ========================================================================
  // Sleep timing: cyclic sense and forced wake share one period counter
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      cyc_sel_l <= `CYC_SEL_RST;
      cyc_en_l <= 1'b0;
      fwu_en_l <= 1'b0;
    end else if (entering && next_mode == sbc_sup_pkg::M_SLEEP) begin
      cyc_sel_l <= CYC_SEL;
      cyc_en_l <= CYC_SENSE_EN;
      fwu_en_l <= FWU_EN;
    end
  end

  always_comb begin
    case (cyc_sel_l)
      3'h0: cyc_period = ms_ticks(`CYC_MS_0);
      3'h1: cyc_period = ms_ticks(`CYC_MS_1);
      3'h2: cyc_period = ms_ticks(`CYC_MS_2);
      3'h3: cyc_period = ms_ticks(`CYC_MS_3);
      3'h4: cyc_period = ms_ticks(`CYC_MS_4);
      3'h5: cyc_period = ms_ticks(`CYC_MS_5);
      3'h6: cyc_period = ms_ticks(`CYC_MS_6);
      default: cyc_period = ms_ticks(`CYC_MS_7);
    endcase
  end

  assign cyc_act = mode == sbc_sup_pkg::M_SLEEP && cyc_en_l && WAKE_INPUTS_ON_SWITCHED_OUTPUT;
  assign fwu_act = mode == sbc_sup_pkg::M_SLEEP && fwu_en_l && !cyc_en_l;

  always_ff @(posedge MCLK) begin
    if (!RSTN || entering || mode != sbc_sup_pkg::M_SLEEP) sleep_cnt <= 20'h00000;
    else if (per_end) sleep_cnt <= 20'h00000;
    else if (tick) sleep_cnt <= sleep_cnt + 20'h00001;
  end
  assign per_end = tick && sleep_cnt == cyc_period - 20'h00001;

  assign v3_cyc = cyc_act && sleep_cnt < 20'(`V3_ON_TICKS);
  assign sample = cyc_act && tick && sleep_cnt == 20'(`SAMPLE_TICKS);
  assign fwu_wake = fwu_act && per_end;

  // ========================================================================
  // Local wake inputs
  always_comb begin
    case (mode)
      sbc_sup_pkg::M_NORMAL, sbc_sup_pkg::M_STANDBY:
        sense_cont = {3{!WAKE_INPUTS_ON_SWITCHED_OUTPUT || SWITCHED_OUTPUT_EN}};
      sbc_sup_pkg::M_SLEEP: sense_cont = {3{!WAKE_INPUTS_ON_SWITCHED_OUTPUT}};
      default: sense_cont = 3'h0;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_wake
      wake_channel u_ch (
        .clk(MCLK),
        .rstn(RSTN),
        .level(wake_s[gi]),
        .sense_en(sense_cont[gi] || cyc_act),
        .cyclic(cyc_act),
        .sample(sample),
        .opt_wr(WAKE_OPT_WR),
        .opt_in(WAKE_OPT[3*gi +: 3]),
        .wake(lw[gi])
      );
    end
  endgenerate

  // A pulse still in flight when sensing stops is dropped
  assign flag_set = lw & (sense_cont | {3{cyc_act}});

  // Set wins over a clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (!RSTN) WAKE_FLAG <= 3'h0;
    else WAKE_FLAG <= (WAKE_FLAG & ~WAKE_FLAG_CLR) | flag_set;
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) WAKE_LIVE <= 3'h0;
    else if (wd_active) WAKE_LIVE <= wake_s;
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) WAKE_INT <= 1'b0;
    else WAKE_INT <= wd_active && |(WAKE_FLAG & WAKE_INT_EN);
  end

  // ========================================================================
  // SPI wake and sleep exit
  assign spi_wake = mode == sbc_sup_pkg::M_SLEEP && v1_off && cs_fall;

  always_ff @(posedge MCLK) begin
    if (!RSTN) SPI_WAKE_FLAG <= 1'b0;
    else if (spi_wake) SPI_WAKE_FLAG <= 1'b1;
    else if (SPI_WAKE_CLR) SPI_WAKE_FLAG <= 1'b0;
  end

  assign sleep_wake = spi_wake || fwu_wake || |flag_set;

  // ========================================================================
  // Outputs
  assign MODE = mode;
  assign CAN_MODE = v2_on ? can_mode : sbc_sup_pkg::CAN_BUS_STANDBY;
  assign FIRST_REGULATOR_EN = mode != sbc_sup_pkg::M_SLEEP && mode != sbc_sup_pkg::M_EMERG;
  assign SECOND_REGULATOR_EN = v2_on;
  assign SWITCHED_BATTERY_OUTPUT = (wd_active && SWITCHED_OUTPUT_EN) || v3_cyc;
  assign RST_N_OUT = FIRST_REGULATOR_EN && rst_cnt == 8'h00;

  // ========================================================================
  // Assertions
  property p_can_standby;
    @(posedge MCLK) disable iff (!RSTN)
    mode != sbc_sup_pkg::M_NORMAL |-> CAN_MODE == sbc_sup_pkg::CAN_BUS_STANDBY;
  endproperty
  a_can_standby: assert property (p_can_standby) else $error("CAN not standby");

  property p_v2_off_sticky;
    @(posedge MCLK) disable iff (!RSTN)
    (v2_on && !$past(v2_on) && !CAN_MODE_WR) |-> can_mode == sbc_sup_pkg::CAN_BUS_STANDBY;
  endproperty
  a_v2_off_sticky: assert property (p_v2_off_sticky) else $error("CAN mode restored");

  property p_wd_idle;
    @(posedge MCLK) disable iff (!RSTN)
    !wd_active ##1 !wd_active |-> wd_cnt == 20'h00000;
  endproperty
  a_wd_idle: assert property (p_wd_idle) else $error("Watchdog counting while idle");

  property p_open_restart;
    @(posedge MCLK) disable iff (!RSTN)
    (wd_active && trig && wd_open) |=> wd_cnt == 20'h00000 && !wd_open;
  endproperty
  a_open_restart: assert property (p_open_restart) else $error("No new closed window");

  property p_closed_reset;
    @(posedge MCLK) disable iff (!RSTN)
    (wd_active && trig && !wd_open) |=> !RST_N_OUT && mode == sbc_sup_pkg::M_NREQ;
  endproperty
  a_closed_reset: assert property (p_closed_reset) else $error("Early trigger no reset");

  property p_wd_expire;
    @(posedge MCLK) disable iff (!RSTN)
    (wd_active && wd_cnt == wd_period) |=> !RST_N_OUT [*2];
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("Expiry no reset");

  property p_nreq_sleep;
    @(posedge MCLK) disable iff (!RSTN)
    (mode == sbc_sup_pkg::M_NREQ && nreq_to && !MODE_WR && !WD_TIMING_WR)
      |=> mode == sbc_sup_pkg::M_SLEEP && !RST_N_OUT;
  endproperty
  a_nreq_sleep: assert property (p_nreq_sleep) else $error("No sleep after timeout");

  property p_v3_window;
    @(posedge MCLK) disable iff (!RSTN)
    sample |-> SWITCHED_BATTERY_OUTPUT ##1 SWITCHED_BATTERY_OUTPUT;
  endproperty
  a_v3_window: assert property (p_v3_window) else $error("Sample outside on time");

  property p_spi_wake;
    @(posedge MCLK) disable iff (!RSTN)
    spi_wake |=> mode == sbc_sup_pkg::M_NREQ && SPI_WAKE_FLAG;
  endproperty
  a_spi_wake: assert property (p_spi_wake) else $error("SPI wake lost");

  property p_flag_set_wins;
    @(posedge MCLK) disable iff (!RSTN)
    |flag_set |=> (WAKE_FLAG & $past(flag_set)) == $past(flag_set);
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("Wake flag lost");

  c_wd_ok: cover property (@(posedge MCLK) disable iff (!RSTN) wd_active && trig && wd_open);
  c_local_wake: cover property (@(posedge MCLK) disable iff (!RSTN)
    mode == sbc_sup_pkg::M_SLEEP && |flag_set);
  c_fwu: cover property (@(posedge MCLK) disable iff (!RSTN) fwu_wake);
  c_spi: cover property (@(posedge MCLK) disable iff (!RSTN) spi_wake);
endmodule // sbc_supervisor

`default_nettype wire

// ### logic/sbc_sup_params.svh
/*
  Timing constants, reset values and period tables of the supervisory block.
  Assumes a 10 MHz core clock; every period but the wake filter, which counts core clock cycles, is counted in ticks of the shared timebase.
*/
`ifndef SBC_SUP_PARAMS_SVH
`define SBC_SUP_PARAMS_SVH

// ==========================================================================
// Clock and timebase
`define CLK_PERIOD_NS 100
`define TICK_US 10
`define TICK_CYCLES ((`TICK_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================================
// Wake input filter (least time, rounded up to whole cycles)
`define FILTER_US 20
`define FILTER_CYCLES ((`FILTER_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================================
// Times counted in timebase ticks
`define RST_PULSE_US 1000
`define RST_PULSE_TICKS (`RST_PULSE_US / `TICK_US)
`define NREQ_TIMEOUT_MS 75
`define NREQ_TIMEOUT_TICKS (`NREQ_TIMEOUT_MS * 1000 / `TICK_US)
`define V3_ON_US 400
`define V3_ON_TICKS (`V3_ON_US / `TICK_US)
`define SAMPLE_US 300
`define SAMPLE_TICKS (`SAMPLE_US / `TICK_US)

// ==========================================================================
// Watchdog period table, closed plus open window, in ms
`define WD_MS_0 5
`define WD_MS_1 10
`define WD_MS_2 20
`define WD_MS_3 33
`define WD_MS_4 50
`define WD_MS_5 75
`define WD_MS_6 100
`define WD_MS_7 200

// ==========================================================================
// Cyclic sense and forced wake period table, in ms
`define CYC_MS_0 32
`define CYC_MS_1 64
`define CYC_MS_2 128
`define CYC_MS_3 256
`define CYC_MS_4 512
`define CYC_MS_5 1024
`define CYC_MS_6 2048
`define CYC_MS_7 8192

// ==========================================================================
// Reset values
`define WD_SEL_RST 3'h0
`define CYC_SEL_RST 3'h0

`endif

// ### logic/sbc_sup_pkg.sv
/*
  Types shared by the supervisory block: chip modes, mode commands, CAN modes and
  wake input options. Assumes nothing of its surroundings.
*/
`default_nettype none

package sbc_sup_pkg;
  // ========================================================================
  // Chip operating modes, one-hot
  typedef enum logic [4:0] {
    M_NREQ    = 5'h01,
    M_NORMAL  = 5'h02,
    M_STANDBY = 5'h04,
    M_SLEEP   = 5'h08,
    M_EMERG   = 5'h10
  } mode_t;

  typedef enum logic [1:0] {
    CMD_NORMAL  = 2'h0,
    CMD_STANDBY = 2'h1,
    CMD_SLEEP   = 2'h2,
    CMD_EMERG   = 2'h3
  } mode_cmd_t;

  typedef enum logic [1:0] {
    CAN_BUS_STANDBY       = 2'h0,
    CAN_RECEIVE_ONLY      = 2'h1,
    CAN_TRANSMIT_RECEIVE  = 2'h2
  } can_mode_t;

  typedef enum logic [2:0] {
    WO_NONE   = 3'h0,
    WO_HIGH   = 3'h1,
    WO_LOW    = 3'h2,
    WO_CHANGE = 3'h3,
    WO_RISE   = 3'h4,
    WO_FALL   = 3'h5,
    WO_BOTH   = 3'h6
  } wake_opt_t;
endpackage

`default_nettype wire

// ### logic/sync2.sv
/*
  Two flip-flop synchroniser for a bundle of unrelated levels.
  Assumes each bit is a slow level; no word coherence is promised.
*/
`default_nettype none

module sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sync2

`default_nettype wire

// ### logic/wake_channel.sv
/*
  One wake input detector: filtered level and change detection for permanent
  sensing, and four-sample edge qualification for cyclic sensing.
  Assumes a synchronised input level and a one-cycle sample strobe.
*/
`include "sbc_sup_params.svh"
`default_nettype none

module wake_channel #(
  parameter int unsigned FILT = `FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic level,
  input wire logic sense_en,
  input wire logic cyclic,
  input wire logic sample,
  input wire logic opt_wr,
  input wire logic [2:0] opt_in,
  output logic wake
);
  sbc_sup_pkg::wake_opt_t opt;
  logic ref_lvl;
  logic target;
  logic edge_ok;
  logic fire;
  logic cyc_hit;
  logic [7:0] cnt;
  logic [3:0] smp;
  logic [2:0] nsmp;

  always_ff @(posedge clk) begin
    if (!rstn) opt <= sbc_sup_pkg::WO_NONE;
    else if (opt_wr) opt <= sbc_sup_pkg::wake_opt_t'(opt_in);
  end

  // Reference for change detection is the level seen when the option is written or when the input last fired
  always_ff @(posedge clk) begin
    if (!rstn) ref_lvl <= 1'b0;
    else if (opt_wr) ref_lvl <= level;
    else if (fire) ref_lvl <= level;
  end

  always_comb begin
    case (opt)
      sbc_sup_pkg::WO_HIGH: target = 1'b1;
      sbc_sup_pkg::WO_LOW: target = 1'b0;
      default: target = ~ref_lvl;
    endcase
  end

  always_comb begin
    case (opt)
      sbc_sup_pkg::WO_RISE: edge_ok = level;
      sbc_sup_pkg::WO_FALL: edge_ok = ~level;
      sbc_sup_pkg::WO_NONE: edge_ok = 1'b0;
      default: edge_ok = 1'b1;
    endcase
  end

  // Saturates above FILT so a held level reports only once
  always_ff @(posedge clk) begin
    if (!rstn || !sense_en || cyclic || opt_wr || level != target) cnt <= 8'h00;
    else if (cnt <= 8'(FILT)) cnt <= cnt + 8'h01;
  end

  assign fire = sense_en && !cyclic && edge_ok && level == target && cnt == 8'(FILT);

  always_ff @(posedge clk) begin
    if (!rstn || !cyclic) begin
      smp <= 4'h0;
      nsmp <= 3'h0;
    end else if (sample && sense_en) begin
      smp <= {smp[2:0], level};
      if (nsmp != 3'h4) nsmp <= nsmp + 3'h1;
    end
  end

  // Oldest sample in bit 3: edges need two of one level then two of the other, levels the newest two
  always_comb begin
    case (opt)
      sbc_sup_pkg::WO_RISE: cyc_hit = smp == 4'h3;
      sbc_sup_pkg::WO_FALL: cyc_hit = smp == 4'hC;
      sbc_sup_pkg::WO_HIGH: cyc_hit = smp[1:0] == 2'h3;
      sbc_sup_pkg::WO_LOW: cyc_hit = smp[1:0] == 2'h0;
      sbc_sup_pkg::WO_NONE: cyc_hit = 1'b0;
      default: cyc_hit = smp == 4'h3 || smp == 4'hC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) wake <= 1'b0;
    else wake <= fire || (cyclic && nsmp == 3'h4 && cyc_hit && !sample);
  end
endmodule // wake_channel

`default_nettype wire

// ### verif/host_model.sv
/*
  Host model: frames one SPI watchdog trigger word per request.
  Assumes go is a one-cycle pulse on clk, launched just after an edge.
*/
`default_nettype none

module host_model (
  // Clock and request
  input wire logic clk,
  input wire logic go,
  // SPI side
  output logic cs_n,
  output logic trig_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Frame
  // Word flag outlives the chip select rise so the synchronised edge still sees it
  initial begin
    cs_n = 1'h1;
    trig_word = 1'h0;
    forever begin
      @(posedge clk);
      if (go) begin
        cs_n <= 1'h0;
        trig_word <= 1'h1;
        repeat (8) @(posedge clk);
        cs_n <= 1'h1;
        repeat (4) @(posedge clk);
        trig_word <= 1'h0;
      end
    end
  end
endmodule // host_model

`default_nettype wire

// ### verif/tb_sbc_supervisor.sv
/*
  Bench of the supervisory block: CAN modes, watchdog windows, local, SPI and forced wake.
  Assumes the tick parameter shortened to one cycle.
*/
`default_nettype none

module tb_sbc_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Signals
  logic MCLK = '0, RSTN = '0, go = '0, FIRST_REGULATOR_OFF = '0, SECOND_REGULATOR_OVERLOAD = '0;
  logic WD_TIMING_WR = '0, MODE_WR = '0, CAN_MODE_WR = '0, WAKE_OPT_WR = '0, SPI_WAKE_CLR = '0;
  logic SWITCHED_OUTPUT_EN = '1, WAKE_INPUTS_ON_SWITCHED_OUTPUT = '0, CYC_SENSE_EN = '0;
  logic FWU_EN = '1, CS_N_PIN, TRIG_WORD, FIRST_REGULATOR_EN, SECOND_REGULATOR_EN;
  logic [2:0] WAKE_PIN = '0, WD_TIMING_SEL = '0, WAKE_FLAG_CLR = '0, CYC_SEL = '0, WAKE_INT_EN = '1;
  logic [1:0] MODE_CMD = '0, CAN_MODE_REQ = '0, CAN_MODE;
  logic [8:0] WAKE_OPT = '0;
  logic [4:0] MODE;
  logic [2:0] WAKE_LIVE, WAKE_FLAG;
  logic SWITCHED_BATTERY_OUTPUT, RST_N_OUT, SPI_WAKE_FLAG, WAKE_INT;
  int err_total = 0, total_checks = 0;
  // Row: write, overload, request, expected CAN mode; last rows show no restore
  logic [5:0] rows [6] = '{6'h2A, 6'h25, 6'h2C, 6'h2A, 6'h18, 6'h00};

  sbc_supervisor #(.TICK_CYCLES(1)) sbc_supervisor_i (.MCLK, .RSTN, .CS_N_PIN, .WAKE_PIN,
    .FIRST_REGULATOR_OFF, .SECOND_REGULATOR_OVERLOAD, .TRIG_WORD, .WD_TIMING_WR,
    .WD_TIMING_SEL, .MODE_WR, .MODE_CMD, .CAN_MODE_WR, .CAN_MODE_REQ, .WAKE_OPT_WR,
    .WAKE_OPT, .WAKE_FLAG_CLR, .SPI_WAKE_CLR, .SWITCHED_OUTPUT_EN,
    .WAKE_INPUTS_ON_SWITCHED_OUTPUT, .CYC_SEL, .CYC_SENSE_EN, .FWU_EN, .WAKE_INT_EN, .MODE,
    .CAN_MODE, .FIRST_REGULATOR_EN, .SECOND_REGULATOR_EN, .SWITCHED_BATTERY_OUTPUT,
    .RST_N_OUT, .WAKE_LIVE, .WAKE_FLAG, .SPI_WAKE_FLAG, .WAKE_INT);
  host_model host_model_i (.clk(MCLK), .go(go), .cs_n(CS_N_PIN), .trig_word(TRIG_WORD));

  always #50 MCLK = ~MCLK;
  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic trig;
    @(posedge MCLK) go <= 1'h1;
    @(posedge MCLK) go <= 1'h0;
    tick(16);
  endtask
  task automatic mode_wr(input logic wd, input sbc_sup_pkg::mode_cmd_t c);
    @(posedge MCLK) begin
      WD_TIMING_WR <= wd;
      MODE_WR <= ~wd;
      MODE_CMD <= c;
    end
    @(posedge MCLK) {WD_TIMING_WR, MODE_WR} <= 2'h0;
    #1;
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    #3000000;
    err_total++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge MCLK);
    RSTN <= 1'h1;
    #1;
    chk("mode", 5'h01, MODE);
    chk("can", 5'h00, CAN_MODE);
    mode_wr(1'h1, sbc_sup_pkg::CMD_NORMAL);
    chk("mode", 5'h02, MODE);
    chk("v2", 5'h01, SECOND_REGULATOR_EN);
    chk("v3", 5'h01, SWITCHED_BATTERY_OUTPUT);
    foreach (rows[i]) begin
      @(posedge MCLK) begin
        CAN_MODE_WR <= rows[i][5];
        SECOND_REGULATOR_OVERLOAD <= rows[i][4];
        CAN_MODE_REQ <= rows[i][3:2];
      end
      @(posedge MCLK) CAN_MODE_WR <= 1'h0;
      tick(4);
      chk("can", rows[i][1:0], CAN_MODE);
    end
    $display("can table done");
    @(posedge MCLK) {WAKE_OPT, WAKE_OPT_WR} <= 10'h003;
    @(posedge MCLK) {WAKE_PIN, WAKE_OPT_WR} <= 4'h6;
    tick(150);
    chk("flag", 5'h00, WAKE_FLAG);
    tick(60);
    chk("flag", 5'h01, WAKE_FLAG);
    chk("live", 5'h03, WAKE_LIVE);
    chk("int", 5'h01, WAKE_INT);
    $display("wake done");
    tick(50);
    trig;
    chk("mode", 5'h02, MODE);
    trig;
    chk("mode", 5'h01, MODE);
    chk("rst", 5'h00, RST_N_OUT);
    $display("window done");
    tick(110);
    mode_wr(1'h0, sbc_sup_pkg::CMD_SLEEP);
    chk("mode", 5'h01, MODE);
    mode_wr(1'h1, sbc_sup_pkg::CMD_NORMAL);
    mode_wr(1'h0, sbc_sup_pkg::CMD_STANDBY);
    chk("mode", 5'h04, MODE);
    tick(510);
    chk("mode", 5'h01, MODE);
    $display("standby timeout done");
    tick(7600);
    chk("mode", 5'h08, MODE);
    chk("v1", 5'h00, FIRST_REGULATOR_EN);
    @(posedge MCLK) {FIRST_REGULATOR_OFF, WAKE_PIN} <= 4'h8;
    trig;
    chk("mode", 5'h01, MODE);
    chk("spiwake", 5'h01, SPI_WAKE_FLAG);
    tick(7700);
    chk("mode", 5'h08, MODE);
    tick(3150);
    chk("mode", 5'h01, MODE);
    chk("rst", 5'h00, RST_N_OUT);
    @(posedge MCLK) WAKE_FLAG_CLR <= 3'h7;
    @(posedge MCLK) WAKE_FLAG_CLR <= 3'h0;
    tick(7700);
    chk("flag", 5'h00, WAKE_FLAG);
    @(posedge MCLK) WAKE_PIN <= 3'h1;
    tick(220);
    chk("mode", 5'h01, MODE);
    chk("flag", 5'h01, WAKE_FLAG);
    $display("sleep wake done");
    final_report;
  end
endmodule // tb_sbc_supervisor

`default_nettype wire
